// File: hw/ptsd_top.sv
// point table store, table selection, command decode and status display
// assumes APB master on pclk; remote bits and link flags are asynchronous levels
// Function
// (R1) drive three-digit link, station, fault display
// (R2) no link: show b plus station
// (R3) servo on after init: d for 2s
// (R4) init or servo off: show C plus station
// (R5) after ready: show executing table number
// (R6) alarm or warning: A plus number only
// (R7) watchdog error: show 888 all lit
// (R8) station field 00 in test, else 01-64
// (R9) warning except AE6 at servo on: blink dp2
// (R10) store 255 tables with six items each
// (R11) master selects table, then start begins positioning
// (R12) absolute: target -999999..999999 scaled by exponent
// (R13) incremental: distance 0..999999 scaled by exponent
// (R14) binary table number from five or eight bits
// (R15) two stations: table number from register too
// (R16) forced stop and servo on give ready
// (R17) cpu error over alarm over ready, table
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
`include "ptsd_consts.svh"
module ptsd_top
   import ptsd_pkg::*;
#(
   parameter int unsigned READY_HOLD_CYC = `PTSD_READY_HOLD_CYC,
   parameter int unsigned BLINK_CYC = `PTSD_BLINK_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic link_up,
   input wire logic cpu_wdog_err,
   input wire logic forced_stop_input,
   input wire logic servo_on_input,
   input wire logic forward_start_input,
   input wire logic reverse_start_input,
   input wire logic [7:0] table_select,
   output logic ready_out,
   output logic start_pulse,
   output logic start_reverse,
   output logic [7:0] exec_table,
   output logic [6:0] seg_dig0,
   output logic [6:0] seg_dig1,
   output logic [6:0] seg_dig2,
   output logic [2:0] seg_dp,
   output logic irq
);
   // pin inputs pass two flip-flops first
   logic [13:0] sync_q;
   ptsd_sync #(.W(14)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d({link_up, cpu_wdog_err, forced_stop_input, servo_on_input,
          forward_start_input, reverse_start_input, table_select}),
      .q(sync_q)
   );
   wire link_s = sync_q[13];
   wire wdog_s = sync_q[12];
   wire estop_s = sync_q[11];
   wire servo_s = sync_q[10];
   wire fwd_s = sync_q[9];
   wire rev_s = sync_q[8];
   wire [7:0] sel_s = sync_q[7:0];

   // registers
   logic [31:0] ctrl;
   logic [3:0] irq_stat;
   logic [3:0] irq_mask;
   logic [7:0] tbl_idx;
   logic [15:0] alarm_reg;
   logic fwd_d, rev_d, servo_ok_d;
   logic [31:0] hold_cnt;
   logic [31:0] blink_cnt;
   logic blink;
   logic signed [31:0] cmd_target;
   logic cmd_incr;
   logic [3:0] cmd_exp;
   ptsd_disp_t disp;
   ptsd_disp_t next_disp;

   // point table memory, index 0 unused (tables 1..255)
   logic signed [31:0] tbl_pos [0:255];
   logic [15:0] tbl_spd [0:255];
   logic [15:0] tbl_acc [0:255];
   logic [15:0] tbl_dec [0:255];
   logic [15:0] tbl_dwl [0:255];
   logic [1:0] tbl_aux [0:255];

   wire two_stn = ctrl[`PTSD_CTRL_TWO_STN];
   wire reg_sel = ctrl[`PTSD_CTRL_REG_SEL];
   wire test_mode = ctrl[`PTSD_CTRL_TEST];
   wire init_done = ctrl[`PTSD_CTRL_INIT_DONE];
   wire incr_sys = ctrl[`PTSD_CTRL_INCR];
   wire [6:0] station = ctrl[`PTSD_CTRL_STN_LSB +: 7];
   wire [7:0] reg_table = ctrl[`PTSD_CTRL_REGTBL_LSB +: 8];
   wire [3:0] feed_length_exponent = ctrl[`PTSD_CTRL_EXP_LSB +: 4];
   wire alarm_act = alarm_reg[8];
   wire warn_act = alarm_reg[9];
   wire [7:0] alarm_no = alarm_reg[7:0];

   // apb decode
   wire apb_acc = psel && penable;
   wire apb_wr = apb_acc && pwrite;
   wire hit_ctrl = paddr == `PTSD_OFS_CTRL;
   wire hit_stat = paddr == `PTSD_OFS_STATUS;
   wire hit_istat = paddr == `PTSD_OFS_IRQ_STAT;
   wire hit_imask = paddr == `PTSD_OFS_IRQ_MASK;
   wire hit_idx = paddr == `PTSD_OFS_TBL_IDX;
   wire hit_pos = paddr == `PTSD_OFS_TBL_POS;
   wire hit_spd = paddr == `PTSD_OFS_TBL_SPD;
   wire hit_acc = paddr == `PTSD_OFS_TBL_ACC;
   wire hit_dec = paddr == `PTSD_OFS_TBL_DEC;
   wire hit_dwl = paddr == `PTSD_OFS_TBL_DWL;
   wire hit_aux = paddr == `PTSD_OFS_TBL_AUX;
   wire hit_alm = paddr == `PTSD_OFS_ALARM;
   wire hit_tgt = paddr == `PTSD_OFS_CMD_TGT;
   wire hit_info = paddr == `PTSD_OFS_CMD_INFO;
   wire hit_any = hit_ctrl || hit_stat || hit_istat || hit_imask || hit_idx || hit_pos
      || hit_spd || hit_acc || hit_dec || hit_dwl || hit_aux || hit_alm || hit_tgt
      || hit_info;
   assign pready = 1'b1;
   assign pslverr = apb_acc && !hit_any;

   // position write clamps to the documented range per command system
   function automatic logic signed [31:0] clamp_pos(input logic signed [31:0] v,
                                                    input logic incr);
      logic signed [31:0] lo;
      lo = incr ? 32'sd0 : `PTSD_POS_MIN;
      if (v > `PTSD_POS_MAX)
         clamp_pos = `PTSD_POS_MAX;
      else if (v < lo)
         clamp_pos = lo;
      else
         clamp_pos = v;
   endfunction

   // table number: five bits, eight with two stations, or register
   wire [7:0] bit_table = two_stn ? sel_s : {3'b000, sel_s[4:0]}; // R14
   wire [7:0] sel_table = (two_stn && reg_sel) ? reg_table : bit_table; // R15

   wire servo_ok = estop_s && servo_s; // R16
   wire fwd_rise = fwd_s && !fwd_d;
   wire rev_rise = rev_s && !rev_d;
   // a start without a valid selection or while not ready is ignored
   wire start_ok = (fwd_rise || rev_rise) && servo_ok && init_done && !alarm_act
      && (sel_table != 8'h00); // R11
   wire ready_rise = servo_ok && !servo_ok_d && init_done;
   wire hold_done = hold_cnt == 32'd0;

   // display priority: cpu error, alarm, link, init, ready, running
   always_comb begin
      next_disp = disp;
      if (wdog_s)
         next_disp = ptsd_cpu_err; // R17
      else if (alarm_act || warn_act)
         next_disp = ptsd_alarm; // R17
      else if (!link_s)
         next_disp = ptsd_wait_link;
      else if (!init_done || !servo_ok)
         next_disp = ptsd_not_ready;
      else if (disp != ptsd_running && disp != ptsd_ready)
         next_disp = ptsd_ready;
      else if (disp == ptsd_ready && hold_done)
         next_disp = ptsd_running; // R5
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         disp <= ptsd_not_ready;
         hold_cnt <= 32'd0;
         fwd_d <= 1'b0;
         rev_d <= 1'b0;
         servo_ok_d <= 1'b0;
         blink_cnt <= 32'd0;
         blink <= 1'b0;
      end else begin
         disp <= next_disp;
         fwd_d <= fwd_s;
         rev_d <= rev_s;
         servo_ok_d <= servo_ok;
         if (next_disp == ptsd_ready && disp != ptsd_ready)
            hold_cnt <= READY_HOLD_CYC - 32'd1; // R3
         else if (!hold_done)
            hold_cnt <= hold_cnt - 32'd1;
         blink_cnt <= (blink_cnt == BLINK_CYC - 32'd1) ? 32'd0 : blink_cnt + 32'd1;
         if (blink_cnt == BLINK_CYC - 32'd1)
            blink <= !blink;
      end
   end

   // start latches the command from the selected table
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         exec_table <= 8'h00;
         start_pulse <= 1'b0;
         start_reverse <= 1'b0;
         cmd_target <= 32'sd0;
         cmd_incr <= 1'b0;
         cmd_exp <= 4'h0;
         ready_out <= 1'b0;
      end else begin
         start_pulse <= start_ok; // R11
         ready_out <= servo_ok && init_done && !alarm_act; // R16
         if (start_ok) begin
            exec_table <= sel_table;
            start_reverse <= rev_rise && !fwd_rise;
            cmd_incr <= incr_sys;
            cmd_exp <= feed_length_exponent;
            // absolute target, or distance added by the profile stage
            cmd_target <= tbl_pos[sel_table]; // R12 R13
         end
      end
   end

   // table store, written through the index register
   always_ff @(posedge pclk) begin
      if (apb_wr && tbl_idx != 8'h00) begin
         if (hit_pos)
            tbl_pos[tbl_idx] <= clamp_pos(pwdata, incr_sys); // R10 R12 R13
         if (hit_spd)
            tbl_spd[tbl_idx] <= pwdata[15:0]; // R10
         if (hit_acc)
            tbl_acc[tbl_idx] <= pwdata[15:0]; // R10
         if (hit_dec)
            tbl_dec[tbl_idx] <= pwdata[15:0]; // R10
         if (hit_dwl)
            tbl_dwl[tbl_idx] <= pwdata[15:0]; // R10
         if (hit_aux)
            tbl_aux[tbl_idx] <= pwdata[1:0]; // R10
      end
   end

   // interrupt events; a new event wins over a write-one clear
   wire [3:0] irq_evt = {ready_rise, wdog_s, alarm_act || warn_act, start_ok};
   wire [3:0] irq_clr = (apb_wr && hit_istat) ? pwdata[3:0] : 4'h0;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `PTSD_CTRL_RESET;
         irq_stat <= 4'h0;
         irq_mask <= 4'h0;
         tbl_idx <= 8'h00;
         alarm_reg <= 16'h0000;
      end else begin
         irq_stat <= (irq_stat & ~irq_clr) | irq_evt;
         if (apb_wr && hit_ctrl)
            ctrl <= pwdata;
         if (apb_wr && hit_imask)
            irq_mask <= pwdata[3:0];
         if (apb_wr && hit_idx)
            tbl_idx <= pwdata[7:0];
         if (apb_wr && hit_alm)
            alarm_reg <= pwdata[15:0];
      end
   end
   assign irq = |(irq_stat & irq_mask);

   wire [31:0] status_word = {16'h0000, exec_table, 1'b0, disp, link_s, wdog_s,
                              ready_out, servo_ok};
   wire [31:0] rd_mux =
      hit_ctrl ? ctrl :
      hit_stat ? status_word :
      hit_istat ? {28'h0, irq_stat} :
      hit_imask ? {28'h0, irq_mask} :
      hit_idx ? {24'h0, tbl_idx} :
      hit_pos ? tbl_pos[tbl_idx] :
      hit_spd ? {16'h0, tbl_spd[tbl_idx]} :
      hit_acc ? {16'h0, tbl_acc[tbl_idx]} :
      hit_dec ? {16'h0, tbl_dec[tbl_idx]} :
      hit_dwl ? {16'h0, tbl_dwl[tbl_idx]} :
      hit_aux ? {30'h0, tbl_aux[tbl_idx]} :
      hit_alm ? {16'h0, alarm_reg} :
      hit_tgt ? cmd_target :
      hit_info ? {23'h0, cmd_incr, 4'h0, cmd_exp} : 32'h0;
   assign prdata = (apb_acc && !pwrite) ? rd_mux : 32'h0;

   // station field: 00 in test mode, else station number in decimal
   wire [6:0] stn_val = test_mode ? 7'd0 : station; // R8
   wire [3:0] stn_tens = 4'((stn_val / 7'd10) % 7'd10); // R8
   wire [3:0] stn_ones = 4'(stn_val % 7'd10); // R8
   wire [3:0] tbl_h = 4'(exec_table / 8'd100);
   wire [3:0] tbl_t = 4'((exec_table / 8'd10) % 8'd10);
   wire [3:0] tbl_o = 4'(exec_table % 8'd10);

   ptsd_char_t k0, k1, k2;
   logic [3:0] v0, v1, v2;
   always_comb begin
      k2 = ptsd_char_dig;
      k1 = ptsd_char_dig;
      k0 = ptsd_char_dig;
      v2 = 4'h0;
      v1 = stn_tens;
      v0 = stn_ones;
      case (disp)
         ptsd_wait_link: k2 = ptsd_char_b; // R2
         ptsd_not_ready: k2 = ptsd_char_c; // R4
         ptsd_ready: k2 = ptsd_char_d; // R3
         ptsd_running: begin
            v2 = tbl_h; // R5
            v1 = tbl_t;
            v0 = tbl_o;
         end
         ptsd_alarm: begin
            k2 = ptsd_char_a; // R6
            v1 = alarm_no[7:4];
            v0 = alarm_no[3:0];
         end
         default: begin
            v2 = 4'h8; // R7
            v1 = 4'h8;
            v0 = 4'h8;
         end
      endcase
   end

   logic [6:0] s0, s1, s2;
   ptsd_seg_enc u_enc2 (.kind(k2), .value(v2), .seg(s2));
   ptsd_seg_enc u_enc1 (.kind(k1), .value(v1), .seg(s1));
   ptsd_seg_enc u_enc0 (.kind(k0), .value(v0), .seg(s0));

   wire dp_flick = warn_act && !alarm_act && servo_ok && alarm_no != `PTSD_WARN_AE6
      && blink && disp == ptsd_alarm; // R9
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seg_dig2 <= 7'h00;
         seg_dig1 <= 7'h00;
         seg_dig0 <= 7'h00;
         seg_dp <= 3'b000;
      end else begin
         seg_dig2 <= s2; // R1
         seg_dig1 <= s1;
         seg_dig0 <= s0;
         seg_dp <= (disp == ptsd_cpu_err) ? 3'b111 : {1'b0, dp_flick, 1'b0};
      end
   end
endmodule

// File: common/ptsd_consts.svh
// constants of the point table select and status display block
// assumes inclusion by bare name from package and design files
`ifndef PTSD_CONSTS_SVH
`define PTSD_CONSTS_SVH
`define PTSD_CLK_MHZ 125
`define PTSD_READY_HOLD_MS 2000
`define PTSD_READY_HOLD_CYC (`PTSD_READY_HOLD_MS * 1000 * `PTSD_CLK_MHZ)
`define PTSD_BLINK_CYC 32'd31250000
`define PTSD_OFS_CTRL 12'h000
`define PTSD_OFS_STATUS 12'h004
`define PTSD_OFS_IRQ_STAT 12'h008
`define PTSD_OFS_IRQ_MASK 12'h00c
`define PTSD_OFS_TBL_IDX 12'h010
`define PTSD_OFS_TBL_POS 12'h014
`define PTSD_OFS_TBL_SPD 12'h018
`define PTSD_OFS_TBL_ACC 12'h01c
`define PTSD_OFS_TBL_DEC 12'h020
`define PTSD_OFS_TBL_DWL 12'h024
`define PTSD_OFS_TBL_AUX 12'h028
`define PTSD_OFS_ALARM 12'h02c
`define PTSD_OFS_CMD_TGT 12'h030
`define PTSD_OFS_CMD_INFO 12'h034
`define PTSD_CTRL_TWO_STN 0
`define PTSD_CTRL_REG_SEL 1
`define PTSD_CTRL_TEST 2
`define PTSD_CTRL_INIT_DONE 3
`define PTSD_CTRL_INCR 4
`define PTSD_CTRL_STN_LSB 8
`define PTSD_CTRL_REGTBL_LSB 16
`define PTSD_CTRL_EXP_LSB 24
`define PTSD_CTRL_RESET 32'h0000_0100
`define PTSD_IRQ_START 0
`define PTSD_IRQ_ALARM 1
`define PTSD_IRQ_WDOG 2
`define PTSD_IRQ_READY 3
`define PTSD_POS_MAX 32'sd999999
`define PTSD_POS_MIN -32'sd999999
`define PTSD_WARN_AE6 8'he6
`define PTSD_SEG_ALL 7'h7f
`endif

// File: common/ptsd_pkg.sv
// types of the point table select and status display block
// assumes ptsd_consts.svh is on the include path
`include "ptsd_consts.svh"
package ptsd_pkg;
   typedef enum logic [2:0] {
      ptsd_wait_link, ptsd_not_ready, ptsd_ready, ptsd_running, ptsd_alarm, ptsd_cpu_err
   } ptsd_disp_t;
   typedef enum logic [2:0] {
      ptsd_char_b, ptsd_char_c, ptsd_char_d, ptsd_char_a, ptsd_char_dig
   } ptsd_char_t;
endpackage

// File: hw/ptsd_seg_enc.sv
// seven-segment encoder for one display digit
// assumes segments gfedcba in bits 6..0, active high
`timescale 1ns/1ps
module ptsd_seg_enc
   import ptsd_pkg::*;
(
   input wire ptsd_char_t kind,
   input wire logic [3:0] value,
   output logic [6:0] seg
);
   always_comb begin
      seg = 7'h00;
      case (kind)
         ptsd_char_b: seg = 7'h7c;
         ptsd_char_c: seg = 7'h39;
         ptsd_char_d: seg = 7'h5e;
         ptsd_char_a: seg = 7'h77;
         default: begin
            case (value)
               4'h0: seg = 7'h3f;
               4'h1: seg = 7'h06;
               4'h2: seg = 7'h5b;
               4'h3: seg = 7'h4f;
               4'h4: seg = 7'h66;
               4'h5: seg = 7'h6d;
               4'h6: seg = 7'h7d;
               4'h7: seg = 7'h07;
               4'h8: seg = 7'h7f;
               4'h9: seg = 7'h6f;
               4'ha: seg = 7'h77;
               4'hb: seg = 7'h7c;
               4'hc: seg = 7'h39;
               4'hd: seg = 7'h5e;
               4'he: seg = 7'h79;
               default: seg = 7'h71;
            endcase
         end
      endcase
   end
endmodule

// File: hw/ptsd_sync.sv
// two flip-flop synchroniser for a bundle of level inputs
// assumes inputs are levels from outside the pclk domain
`timescale 1ns/1ps
module ptsd_sync #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// File: tb/ptsd_properties.sv
// port assertions for ptsd_top
// assumes one pclk domain, presetn active low
`timescale 1ns/1ps
module ptsd_properties (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic cpu_wdog_err,
   input wire logic servo_on_input,
   input wire logic forward_start_input,
   input wire logic reverse_start_input,
   input wire logic ready_out,
   input wire logic start_pulse,
   input wire logic [7:0] exec_table,
   input wire logic [6:0] seg_dig0,
   input wire logic [6:0] seg_dig1,
   input wire logic [6:0] seg_dig2
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic acc = psel && penable;
   // 2 sync stages, state and segment registers need 5
   sequence s_wdog_held;
      cpu_wdog_err [*5];
   endsequence
   sequence s_servo_off;
      !servo_on_input [*4];
   endsequence
   property p_pready;
      acc |-> pready;
   endproperty
   property p_slverr_idle;
      !acc |-> !pslverr;
   endproperty
   property p_rdata_idle;
      !(acc && !pwrite) |-> prdata == 32'h0;
   endproperty
   property p_start_once;
      start_pulse |=> !start_pulse;
   endproperty
   property p_start_cause;
      start_pulse |-> forward_start_input || reverse_start_input;
   endproperty
   property p_start_table;
      start_pulse |-> exec_table != 8'h00;
   endproperty
   property p_exec_hold;
      !start_pulse |-> $stable(exec_table);
   endproperty
   property p_wdog_seg;
      s_wdog_held |-> seg_dig0 == 7'h7f && seg_dig1 == 7'h7f && seg_dig2 == 7'h7f;
   endproperty
   property p_ready_off;
      s_servo_off |-> !ready_out;
   endproperty
   a_pready: assert property (p_pready)
      else $error("pready low in access phase");
   a_slverr_idle: assert property (p_slverr_idle)
      else $error("pslverr outside access phase");
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("prdata nonzero outside read access");
   a_start_once: assert property (p_start_once)
      else $error("start pulse longer than one cycle");
   a_start_cause: assert property (p_start_cause)
      else $error("start pulse without start input");
   a_start_table: assert property (p_start_table)
      else $error("start with table zero");
   a_exec_hold: assert property (p_exec_hold)
      else $error("executing table changed without start");
   a_wdog_seg: assert property (p_wdog_seg)
      else $error("watchdog error not shown as all lit");
   a_ready_off: assert property (p_ready_off)
      else $error("ready without servo on");
endmodule
bind ptsd_top ptsd_properties u_ptsd_properties (.pclk, .presetn, .psel, .penable, .pwrite,
   .prdata, .pready, .pslverr, .cpu_wdog_err, .servo_on_input, .forward_start_input,
   .reverse_start_input, .ready_out, .start_pulse, .exec_table, .seg_dig0, .seg_dig1, .seg_dig2);

// File: tb/ptsd_master_model.sv
// fieldbus master stand-in: remote table bits and start inputs
// assumes pclk of the block; levels change just after a rising edge
`timescale 1ns/1ps
module ptsd_master_model (
   input wire logic pclk,
   input wire logic start_pulse,
   input wire logic start_reverse,
   input wire logic [7:0] exec_table,
   output logic forward_start_input,
   output logic reverse_start_input,
   output logic [7:0] table_select
);
   initial begin
      forward_start_input = 1'b0;
      reverse_start_input = 1'b0;
      table_select = 8'h00;
   end
   // got = {seen, reverse, table}; start held well past the sync delay
   task automatic fire(input logic rev, input logic [7:0] tbl, output logic [9:0] got);
      got = 10'h000;
      @(posedge pclk);
      table_select <= tbl;
      repeat (3) @(posedge pclk);
      forward_start_input <= !rev;
      reverse_start_input <= rev;
      repeat (6) begin
         @(negedge pclk);
         if (start_pulse === 1'b1) got = {1'b1, start_reverse, exec_table};
         @(posedge pclk);
      end
      forward_start_input <= 1'b0;
      reverse_start_input <= 1'b0;
      repeat (3) @(posedge pclk);
   endtask
endmodule

// File: tb/ptsd_top_tb_top.sv
// self-checking bench for ptsd_top over APB and remote inputs
// assumes checker bind and master model compiled first
`timescale 1ns/1ps
`include "ptsd_consts.svh"
module ptsd_top_tb_top;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic pready, pslverr, ready_out, start_pulse, start_reverse, irq, err;
   logic link_up = 1'b0, cpu_wdog_err = 1'b0, forced_stop_input = 1'b0, servo_on_input = 1'b0;
   logic forward_start_input, reverse_start_input;
   logic [7:0] table_select, exec_table;
   logic [6:0] seg_dig0, seg_dig1, seg_dig2;
   logic [2:0] seg_dp;
   logic [9:0] got;
   logic [31:0] pos_in[3] = '{32'd1234, 32'd2000000, 32'hffe17b80};
   logic [31:0] pos_exp[3] = '{32'd1234, 32'd999999, 32'hfff0bdc1};
   logic [31:0] ctrl_v[5] = '{32'h108, 32'h108, 32'h108, 32'h109, 32'h7010b};
   logic [7:0] sel_v[5] = '{8'h03, 8'hff, 8'h20, 8'hff, 8'h01};
   logic [9:0] exp_v[5] = '{10'h203, 10'h31f, 10'h000, 10'h3ff, 10'h207};
   int fail_count = 0, samples_checked = 0, cycles = 0;
   initial forever #4 pclk = ~pclk;
   ptsd_top #(.READY_HOLD_CYC(20), .BLINK_CYC(4)) u_ptsd_top (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .link_up, .cpu_wdog_err,
      .forced_stop_input, .servo_on_input, .forward_start_input, .reverse_start_input,
      .table_select, .ready_out, .start_pulse, .start_reverse, .exec_table, .seg_dig0,
      .seg_dig1, .seg_dig2, .seg_dp, .irq);
   ptsd_master_model u_master (.pclk, .start_pulse, .start_reverse, .exec_table,
      .forward_start_input, .reverse_start_input, .table_select);
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      logic rdy;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // answer taken at the very edge where pready is sampled high
      do begin
         @(posedge pclk);
         rdy = pready;
         rdat = prdata;
         err = pslverr;
         n++;
      end while (rdy !== 1'b1 && n < 50);
      if (rdy !== 1'b1) begin
         fail_count++;
         summarize();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(rdat, exp);
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         fail_count++;
         summarize();
      end
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check({31'h0, irq}, 32'h0);
      rd(`PTSD_OFS_CTRL, `PTSD_CTRL_RESET);
      check({11'h0, seg_dig2, seg_dig1, seg_dig0}, {11'h0, 7'h7c, 7'h3f, 7'h06});
      apb(1'b0, 12'h0fc, 32'h0);
      check({rdat[30:0], err}, 32'h1);
      apb(1'b1, `PTSD_OFS_CTRL, 32'h108);
      apb(1'b1, `PTSD_OFS_TBL_IDX, 32'h3);
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, `PTSD_OFS_TBL_POS, pos_in[i]);
         rd(`PTSD_OFS_TBL_POS, pos_exp[i]);
      end
      apb(1'b1, `PTSD_OFS_TBL_SPD, 32'h1234);
      rd(`PTSD_OFS_TBL_SPD, 32'h1234);
      apb(1'b1, `PTSD_OFS_CTRL, 32'h118);
      apb(1'b1, `PTSD_OFS_TBL_POS, 32'hfffffffb);
      rd(`PTSD_OFS_TBL_POS, 32'h0);
      link_up <= 1'b1;
      forced_stop_input <= 1'b1;
      servo_on_input <= 1'b1;
      repeat (6) @(posedge pclk);
      check({31'h0, ready_out}, 32'h1);
      for (int i = 0; i < 5; i++) begin
         apb(1'b1, `PTSD_OFS_CTRL, ctrl_v[i]);
         u_master.fire(exp_v[i][8], sel_v[i], got);
         check({22'h0, got}, {22'h0, exp_v[i]});
      end
      check({11'h0, seg_dig2, seg_dig1, seg_dig0}, {11'h0, 7'h3f, 7'h3f, 7'h07});
      rd(`PTSD_OFS_IRQ_STAT, 32'h9);
      apb(1'b1, `PTSD_OFS_IRQ_MASK, 32'h0);
      check({31'h0, irq}, 32'h0);
      apb(1'b1, `PTSD_OFS_IRQ_MASK, 32'hf);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, `PTSD_OFS_IRQ_STAT, 32'hf);
      rd(`PTSD_OFS_IRQ_STAT, 32'h0);
      check({31'h0, irq}, 32'h0);
      apb(1'b1, `PTSD_OFS_ALARM, 32'h201);
      // warning at servo on: second point must be seen both lit and dark
      rdat = 32'h0;
      repeat (12) begin
         @(posedge pclk);
         rdat = rdat | {30'h0, seg_dp[1], !seg_dp[1]};
      end
      check(rdat, 32'h3);
      apb(1'b1, `PTSD_OFS_ALARM, 32'h112);
      repeat (2) @(posedge pclk);
      check({11'h0, seg_dig2, seg_dig1, seg_dig0}, {11'h0, 7'h77, 7'h06, 7'h5b});
      cpu_wdog_err <= 1'b1;
      repeat (5) @(posedge pclk);
      check({8'h0, seg_dp, seg_dig2, seg_dig1, seg_dig0},
            {8'h0, 3'b111, {3{`PTSD_SEG_ALL}}});
      rd(`PTSD_OFS_IRQ_STAT, 32'h6);
      // alarm cleared so ready can only fall through servo off
      apb(1'b1, `PTSD_OFS_ALARM, 32'h0);
      servo_on_input <= 1'b0;
      repeat (6) @(posedge pclk);
      check({31'h0, ready_out}, 32'h0);
      summarize();
   end
endmodule
